// file: core/kmh_consts.svh
/*
 * Constants of the keyboard/mouse host port: port addresses, status and
 * configuration bit positions, commands, reset values and link timing.
 * Assumes inclusion by bare name from the modules.
 */
`ifndef KMH_CONSTS_SVH
`define KMH_CONSTS_SVH

// ------------------------------------------------------------
// Host I/O ports
// ------------------------------------------------------------
`define KMH_PORT_DATA       8'h60
`define KMH_PORT_CMD        8'h64

// ------------------------------------------------------------
// Status bit positions
// ------------------------------------------------------------
`define KMH_ST_PARITY       7
`define KMH_ST_TIMEOUT      6
`define KMH_ST_MOUSE        5
`define KMH_ST_UNLOCK       4
`define KMH_ST_CMD          3
`define KMH_ST_SYS          2
`define KMH_ST_IBF          1
`define KMH_ST_OBF          0

// ------------------------------------------------------------
// Configuration byte bit positions and reset value
// ------------------------------------------------------------
`define KMH_CF_RSVD         7
`define KMH_CF_XLAT         6
`define KMH_CF_MSDIS        5
`define KMH_CF_KBDIS        4
`define KMH_CF_LOCKOVR      3
`define KMH_CF_SYS          2
`define KMH_CF_MSIRQ        1
`define KMH_CF_KBIRQ        0
`define KMH_CFG_RESET       8'h00
`define KMH_CFG_RAM_ADDR    8'h20

// ------------------------------------------------------------
// Commands
// ------------------------------------------------------------
`define KMH_CMD_RDCFG       8'h20
`define KMH_CMD_WRCFG       8'h60
`define KMH_CMD_MSDIS       8'hA7
`define KMH_CMD_MSEN        8'hA8
`define KMH_CMD_KBDIS       8'hAD
`define KMH_CMD_KBEN        8'hAE

// ------------------------------------------------------------
// AHB-Lite controller registers (byte offsets)
// ------------------------------------------------------------
`define KMH_REG_CTRL        8'h00
`define KMH_REG_STATUS      8'h04
`define KMH_REG_RDATA       8'h08
`define KMH_CTRL_GO         8
`define KMH_CTRL_READ       9
`define KMH_CTRL_PORT       10

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define KMH_CLK_NS          4
`define KMH_HOLD_NS         16
`define KMH_HOLD_CYC        ((`KMH_HOLD_NS + `KMH_CLK_NS - 1) / `KMH_CLK_NS)
`define KMH_KBD_TIMEOUT_US  2
`define KMH_KBD_TIMEOUT_CYC (`KMH_KBD_TIMEOUT_US * 1000 / `KMH_CLK_NS)

`endif

// file: core/kmh_pkg.sv
/*
 * Types of the keyboard/mouse host port: the byte type shared by both ends and each end's state type.
 * Assumes kmh_consts.svh is on the include path.
 */
package kmh_pkg;

    typedef logic [7:0] kmh_byte_t;

    typedef enum logic [1:0]
    {
        KMH_ACC_IDLE,
        KMH_ACC_STROBE,
        KMH_ACC_WAIT
    } kmh_acc_e;

    typedef enum logic [1:0]
    {
        KMH_EX_IDLE,
        KMH_EX_WRCFG
    } kmh_ex_e;

endpackage

// file: core/kmh_io_if.sv
/*
 * I/O strobe link between the host processor end and the keyboard
 * controller end. Assumes both ends share clk; strobes are one cycle.
 */
`timescale 1ns/1ps
interface kmh_io_if;
    import kmh_pkg::*;
    logic       ioRd;
    logic       ioWr;
    logic       portCmd;
    kmh_byte_t  wrData;
    kmh_byte_t  rdData;
    logic       rdValid;
    logic       irqKbd;
    logic       irqMouse;

    modport device
    (
        input  ioRd,
        input  ioWr,
        input  portCmd,
        input  wrData,
        output rdData,
        output rdValid,
        output irqKbd,
        output irqMouse
    );

    modport host
    (
        output ioRd,
        output ioWr,
        output portCmd,
        output wrData,
        input  rdData,
        input  rdValid,
        input  irqKbd,
        input  irqMouse
    );
endinterface

// file: core/kmh_kbd_ctrl.sv
/*
 * Keyboard/mouse controller end: status register, single input buffer,
 * output buffer, configuration byte and command interpreter.
 * Assumes a host on the same clock issuing one-cycle read/write strobes,
 * and keyboard/mouse receivers delivering bytes, with parity/timeout flags on keyboard bytes only.
 */
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "kmh_consts.svh"
module kmh_kbd_ctrl
(
    input  wire logic            clk,
    input  wire logic            rst,
    kmh_io_if.device             io,
    input  wire logic            kbdValid,
    input  wire kmh_pkg::kmh_byte_t kbdCode,
    input  wire logic            kbdParityErr,
    input  wire logic            kbdTimeout,
    input  wire logic            mouseValid,
    input  wire kmh_pkg::kmh_byte_t mouseCode,
    input  wire logic            lockSwitchInput,
    output logic                 kbdClockLineOut,
    output logic                 kbdClockLineOe,
    output logic                 mouseEnable,
    output logic                 translateEnable,
    output kmh_pkg::kmh_byte_t   hostCmdByte,
    output logic                 hostCmdValid
);
    import kmh_pkg::*;

    typedef struct packed
    {
        kmh_byte_t  inBuf;
        logic       ibf;
        logic       cmdFlag;
        kmh_byte_t  outBuf;
        logic       obf;
        logic       mouseData;
        logic       parityErr;
        logic       timeoutErr;
        kmh_byte_t  cfgByte;
        kmh_ex_e    exState;
        kmh_byte_t  rdData;
        logic       rdValid;
        logic       irqKbd;
        logic       irqMouse;
        logic       lockMeta;
        logic       lockSync;
        logic       kbdClkOe;
        logic       kbdRxEn;
        logic       mouseEn;
        logic       xlatEn;
        kmh_byte_t  cmdOut;
        logic       cmdOutValid;
    } kmh_dev_s;

    kmh_dev_s   cur;
    kmh_dev_s   next_cur;
    kmh_byte_t  status;
    logic       unlocked;
    kmh_byte_t  kbdXlat;

    // ------------------------------------------------------------
    // Status assembly
    // ------------------------------------------------------------
    always_comb
    begin
        unlocked = ~cur.lockSync | cur.cfgByte[`KMH_CF_LOCKOVR];
        status = 8'h00;
        status[`KMH_ST_PARITY]  = cur.parityErr;
        status[`KMH_ST_TIMEOUT] = cur.timeoutErr;
        status[`KMH_ST_MOUSE]   = cur.obf & cur.mouseData;
        status[`KMH_ST_UNLOCK]  = unlocked;
        status[`KMH_ST_CMD]     = cur.cmdFlag;
        status[`KMH_ST_SYS]     = cur.cfgByte[`KMH_CF_SYS];
        status[`KMH_ST_IBF]     = cur.ibf;
        status[`KMH_ST_OBF]     = cur.obf;
        // Simple translation stand-in: set-2 codes fold their top bit
        kbdXlat = cur.cfgByte[`KMH_CF_XLAT] ? {1'b0, kbdCode[6:0]} : kbdCode;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;
        next_cur.rdValid = 1'b0;
        next_cur.irqKbd = 1'b0;
        next_cur.irqMouse = 1'b0;
        next_cur.cmdOutValid = 1'b0;
        // Lock switch is a pin: two flops before use
        next_cur.lockMeta = lockSwitchInput;
        next_cur.lockSync = cur.lockMeta;

        // Host reads answer on the next cycle
        if (io.ioRd)
        begin
            next_cur.rdValid = 1'b1;
            if (io.portCmd)
                next_cur.rdData = status;
            else
            begin
                next_cur.rdData = cur.outBuf;
                next_cur.obf = 1'b0;
                next_cur.mouseData = 1'b0;
            end
        end

        // Receiver events; parity/timeout reflect the last keyboard byte
        if (kbdValid && cur.kbdRxEn && unlocked)
        begin
            next_cur.parityErr = kbdParityErr;
            next_cur.timeoutErr = kbdTimeout;
        end
        if (!next_cur.obf)
        begin
            if (kbdValid && cur.kbdRxEn && unlocked)
            begin
                next_cur.outBuf = kbdXlat;
                next_cur.obf = 1'b1;
                next_cur.mouseData = 1'b0;
                next_cur.irqKbd = cur.cfgByte[`KMH_CF_KBIRQ];
            end
            else if (mouseValid && cur.mouseEn)
            begin
                next_cur.outBuf = mouseCode;
                next_cur.obf = 1'b1;
                next_cur.mouseData = 1'b1;
                next_cur.irqMouse = cur.cfgByte[`KMH_CF_MSIRQ];
            end
        end

        // Internal controller consumes the input buffer one cycle after fill
        if (cur.ibf)
        begin
            next_cur.ibf = 1'b0;
            if (cur.cmdFlag)
            begin
                next_cur.exState = KMH_EX_IDLE;
                unique case (cur.inBuf)
                    `KMH_CMD_RDCFG:
                    begin
                        next_cur.outBuf = cur.cfgByte;
                        next_cur.obf = 1'b1;
                        next_cur.mouseData = 1'b0;
                    end
                    `KMH_CMD_WRCFG: next_cur.exState = KMH_EX_WRCFG;
                    `KMH_CMD_MSDIS: next_cur.cfgByte[`KMH_CF_MSDIS] = 1'b1;
                    `KMH_CMD_MSEN:  next_cur.cfgByte[`KMH_CF_MSDIS] = 1'b0;
                    `KMH_CMD_KBDIS: next_cur.cfgByte[`KMH_CF_KBDIS] = 1'b1;
                    `KMH_CMD_KBEN:  next_cur.cfgByte[`KMH_CF_KBDIS] = 1'b0;
                    default:
                    begin
                        next_cur.cmdOut = cur.inBuf;
                        next_cur.cmdOutValid = 1'b1;
                    end
                endcase
            end
            else if (cur.exState == KMH_EX_WRCFG)
            begin
                // Reserved bit forced low in case the host breaks its side
                next_cur.cfgByte = {1'b0, cur.inBuf[6:0]};
                next_cur.exState = KMH_EX_IDLE;
            end
        end

        // A host write wins over consumption in the same cycle
        if (io.ioWr)
        begin
            next_cur.inBuf = io.wrData;
            next_cur.ibf = 1'b1;
            next_cur.cmdFlag = io.portCmd;
        end

        next_cur.kbdClkOe = next_cur.cfgByte[`KMH_CF_KBDIS];
        next_cur.kbdRxEn = ~next_cur.cfgByte[`KMH_CF_KBDIS];
        next_cur.mouseEn = ~next_cur.cfgByte[`KMH_CF_MSDIS];
        next_cur.xlatEn = next_cur.cfgByte[`KMH_CF_XLAT];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.cfgByte <= `KMH_CFG_RESET;
            cur.exState <= KMH_EX_IDLE;
            cur.kbdRxEn <= 1'b1;
            cur.mouseEn <= 1'b1;
        end
        else
            cur <= next_cur;
    end

    assign io.rdData = cur.rdData;
    assign io.rdValid = cur.rdValid;
    assign io.irqKbd = cur.irqKbd;
    assign io.irqMouse = cur.irqMouse;
    assign kbdClockLineOut = 1'b0;
    assign kbdClockLineOe = cur.kbdClkOe;
    assign mouseEnable = cur.mouseEn;
    assign translateEnable = cur.xlatEn;
    assign hostCmdByte = cur.cmdOut;
    assign hostCmdValid = cur.cmdOutValid;
endmodule

// file: core/kmh_host_ctrl.sv
/*
 * Host processor end: an AHB-Lite slave whose registers order one I/O
 * read or write of port 60H/64H and return the result.
 * Assumes a single AHB-Lite master on clk, word transfers only.
 */
`timescale 1ns/1ps
`include "kmh_consts.svh"
module kmh_host_ctrl
(
    input  wire logic            clk,
    input  wire logic            rst,
    kmh_io_if.host               io,
    input  wire logic            hsel,
    input  wire logic [7:0]      haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic [31:0]          hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic                 irq1,
    output logic                 irq12
);
    import kmh_pkg::*;

    typedef struct packed
    {
        logic       wrPend;
        logic [7:0] addr;
        kmh_acc_e   acc;
        logic       isRead;
        logic       isCmdPort;
        kmh_byte_t  data;
        kmh_byte_t  result;
        logic       done;
        logic       ioRd;
        logic       ioWr;
        logic       portCmd;
        kmh_byte_t  wrData;
        logic [31:0] rdata;
        logic       irq1;
        logic       irq12;
    } kmh_host_s;

    kmh_host_s  cur;
    kmh_host_s  next_cur;
    logic       busy;

    // ------------------------------------------------------------
    // Bus slave and I/O sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;
        next_cur.ioRd = 1'b0;
        next_cur.ioWr = 1'b0;
        next_cur.irq1 = io.irqKbd;
        next_cur.irq12 = io.irqMouse;
        busy = (cur.acc != KMH_ACC_IDLE);

        if (hready)
        begin
            next_cur.wrPend = hsel & htrans[1] & hwrite;
            next_cur.addr = haddr;
            if (hsel && htrans[1] && !hwrite)
            begin
                unique case (haddr)
                    `KMH_REG_STATUS: next_cur.rdata = {30'h0, cur.done, busy};
                    `KMH_REG_RDATA:  next_cur.rdata = {24'h0, cur.result};
                    `KMH_REG_CTRL:   next_cur.rdata = {21'h0, cur.isCmdPort, cur.isRead, 1'b0, cur.data};
                    default:         next_cur.rdata = 32'h0;
                endcase
            end
        end

        unique case (cur.acc)
            KMH_ACC_IDLE:
            begin
                if (cur.wrPend && cur.addr == `KMH_REG_CTRL && hwdata[`KMH_CTRL_GO])
                begin
                    next_cur.isRead = hwdata[`KMH_CTRL_READ];
                    next_cur.isCmdPort = hwdata[`KMH_CTRL_PORT];
                    next_cur.data = hwdata[7:0];
                    next_cur.done = 1'b0;
                    next_cur.acc = KMH_ACC_STROBE;
                end
            end
            KMH_ACC_STROBE:
            begin
                // Commands go to 64H, data to 60H
                next_cur.portCmd = cur.isCmdPort;
                next_cur.wrData = cur.data;
                next_cur.ioRd = cur.isRead;
                next_cur.ioWr = ~cur.isRead;
                next_cur.acc = cur.isRead ? KMH_ACC_WAIT : KMH_ACC_IDLE;
                next_cur.done = ~cur.isRead;
            end
            KMH_ACC_WAIT:
            begin
                if (io.rdValid)
                begin
                    next_cur.result = io.rdData;
                    next_cur.done = 1'b1;
                    next_cur.acc = KMH_ACC_IDLE;
                end
            end
            default: next_cur.acc = KMH_ACC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.acc <= KMH_ACC_IDLE;
        end
        else
            cur <= next_cur;
    end

    assign io.ioRd = cur.ioRd;
    assign io.ioWr = cur.ioWr;
    assign io.portCmd = cur.portCmd;
    assign io.wrData = cur.wrData;
    assign hrdata = cur.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq1 = cur.irq1;
    assign irq12 = cur.irq12;
endmodule

// file: verification/kmh_io_monitor.sv
/* Checker of the strobe link between the host end and the controller end.
   Assumes one shared clock and the interface signals as plain inputs. */
`timescale 1ns/1ps
`include "kmh_consts.svh"
module kmh_io_monitor
(
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               ioRd,
    input wire logic               ioWr,
    input wire logic               portCmd,
    input wire kmh_pkg::kmh_byte_t wrData,
    input wire kmh_pkg::kmh_byte_t rdData,
    input wire logic               rdValid,
    input wire logic               irqKbd,
    input wire logic               irqMouse
);
    import kmh_pkg::*;
    // ----------------------------------------
    // Shadow of the configuration byte
    // ----------------------------------------
    kmh_byte_t cfg;
    logic      cfgWait, cfgRd, lastCmd, wrSeen;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg     <= `KMH_CFG_RESET;
            cfgWait <= 1'b0;
            cfgRd   <= 1'b0;
            lastCmd <= 1'b0;
            wrSeen  <= 1'b0;
        end
        else if (ioWr)
        begin
            wrSeen  <= 1'b1;
            lastCmd <= portCmd;
            cfgWait <= portCmd && wrData == `KMH_CMD_WRCFG;
            cfgRd   <= portCmd && wrData == `KMH_CMD_RDCFG;
            // Reserved top bit never reaches the stored byte
            if (!portCmd && cfgWait)
                cfg <= wrData & 8'h7F;
            if (portCmd && wrData == `KMH_CMD_MSDIS)
                cfg[5] <= 1'b1;
            if (portCmd && wrData == `KMH_CMD_MSEN)
                cfg[5] <= 1'b0;
            if (portCmd && wrData == `KMH_CMD_KBDIS)
                cfg[4] <= 1'b1;
            if (portCmd && wrData == `KMH_CMD_KBEN)
                cfg[4] <= 1'b0;
        end
        else if (ioRd && !portCmd)
            cfgRd <= 1'b0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_read_answer_next:
        assert property (ioRd |=> rdValid) else $error("read not answered next cycle");
    a_answer_needs_read:
        assert property (rdValid |-> $past(ioRd)) else $error("answer without read");
    a_write_strobe_single:
        assert property (ioWr |=> !ioWr) else $error("write strobe longer than one cycle");
    a_no_read_write:
        assert property (!(ioRd && ioWr)) else $error("read and write together");
    a_one_irq_source:
        assert property (!(irqKbd && irqMouse)) else $error("both interrupts at once");
    a_cfg_read_back:
        assert property (ioRd && !portCmd && cfgRd |=> rdData == cfg) else $error("config readback wrong");
    a_status_sys_flag:
        assert property (ioRd && portCmd |=> rdData[2] == cfg[2]) else $error("system flag wrong");
    a_status_cmd_flag:
        assert property (ioRd && portCmd && wrSeen |=> rdData[3] == lastCmd) else $error("command flag wrong");
    a_kbd_irq_gate:
        assert property (irqKbd |-> cfg[0]) else $error("keyboard interrupt while masked");
    a_mouse_irq_gate:
        assert property (irqMouse |-> cfg[1]) else $error("mouse interrupt while masked");

    c_cfg_read: cover property (ioRd && !portCmd && cfgRd);
    c_kbd_irq: cover property (irqKbd);
    c_mouse_irq: cover property (irqMouse);
endmodule

// file: verification/kbd_mouse_host_port_tb.sv
/* Self-checking bench: both ends joined by the link, host driven over AHB-Lite.
   Assumes the design files and kmh_consts.svh on the include path. */
`timescale 1ns/1ps
`include "kmh_consts.svh"
module kbd_mouse_host_port_tb;
    import kmh_pkg::*;
    logic        clk, rst, hsel, hwrite, hready, hresp, irq1, irq12;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        kbdValid, kbdParityErr, kbdTimeout, mouseValid, lockSwitchInput;
    kmh_byte_t   kbdCode, mouseCode, hostCmdByte, s, r;
    logic        kbdClockLineOut, kbdClockLineOe, mouseEnable, translateEnable, hostCmdValid;
    int          nMismatch = 0, compares = 0, irq1Cnt = 0, irq12Cnt = 0, cmdCnt = 0, n;

    kmh_io_if io();
    kmh_kbd_ctrl kmh_kbd_ctrl_inst(.clk(clk), .rst(rst), .io(io.device), .kbdValid(kbdValid),
        .kbdCode(kbdCode), .kbdParityErr(kbdParityErr), .kbdTimeout(kbdTimeout), .mouseValid(mouseValid),
        .mouseCode(mouseCode), .lockSwitchInput(lockSwitchInput), .kbdClockLineOut(kbdClockLineOut),
        .kbdClockLineOe(kbdClockLineOe), .mouseEnable(mouseEnable), .translateEnable(translateEnable),
        .hostCmdByte(hostCmdByte), .hostCmdValid(hostCmdValid));
    kmh_host_ctrl kmh_host_ctrl_inst(.clk(clk), .rst(rst), .io(io.host), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .irq1(irq1), .irq12(irq12));
    kmh_io_monitor kmh_io_monitor_inst(.clk(clk), .rst(rst), .ioRd(io.ioRd), .ioWr(io.ioWr),
        .portCmd(io.portCmd), .wrData(io.wrData), .rdData(io.rdData), .rdValid(io.rdValid),
        .irqKbd(io.irqKbd), .irqMouse(io.irqMouse));

    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        irq1Cnt  <= irq1Cnt + (irq1 === 1'b1);
        irq12Cnt <= irq12Cnt + (irq12 === 1'b1);
        cmdCnt   <= cmdCnt + (hostCmdValid === 1'b1);
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_ready;
        int i;
        i = 0;
        @(posedge clk);
        while (hready !== 1'b1)
        begin
            if (++i > 100)
            begin
                nMismatch++;
                print_verdict();
            end
            @(posedge clk);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    // One port access; polling for done because the link latency is not ours to assume
    task automatic host_io(input logic rd, input logic cmd, input kmh_byte_t b, output kmh_byte_t res);
        logic [31:0] d;
        int          i;
        ahb(1'b1, `KMH_REG_CTRL, {21'h0, cmd, rd, 1'b1, b}, d);
        i = 0;
        d = 32'h0;
        while (d[1:0] !== 2'b10)
        begin
            ahb(1'b0, `KMH_REG_STATUS, 32'h0, d);
            if (++i > 50)
            begin
                nMismatch++;
                print_verdict();
            end
        end
        ahb(1'b0, `KMH_REG_RDATA, 32'h0, d);
        res = d[7:0];
    endtask
    task automatic status(output kmh_byte_t v);
        host_io(1'b1, 1'b1, 8'h00, v);
    endtask
    task automatic cmd(input kmh_byte_t b);
        kmh_byte_t x;
        host_io(1'b0, 1'b1, b, x);
    endtask
    task automatic set_cfg(input kmh_byte_t v);
        kmh_byte_t x;
        cmd(`KMH_CMD_WRCFG);
        host_io(1'b0, 1'b0, v, x);
    endtask
    task automatic read_data(output kmh_byte_t v);
        host_io(1'b1, 1'b0, 8'h00, v);
    endtask
    task automatic kbd_byte(input kmh_byte_t c, input logic par, input logic tmo);
        kbdCode      <= c;
        kbdParityErr <= par;
        kbdTimeout   <= tmo;
        kbdValid     <= 1'b1;
        @(posedge clk);
        kbdValid     <= 1'b0;
    endtask
    task automatic mouse_byte(input kmh_byte_t c);
        mouseCode  <= c;
        mouseValid <= 1'b1;
        @(posedge clk);
        mouseValid <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        status(s);       check(s, 8'h10);
        cmd(`KMH_CMD_RDCFG);
        read_data(r);    check(r, `KMH_CFG_RESET);
        ahb(1'b0, 8'h0C, 32'h0, d);
        check(d, 32'h0);
        check(hresp, 1'b0);
        check(mouseEnable, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_config;
        set_cfg(8'h44);
        status(s);       check(s, 8'h14);
        check(translateEnable, 1'b1);
        cmd(`KMH_CMD_RDCFG);
        status(s);       check(s, 8'h1D);
        read_data(r);    check(r, 8'h44);
        status(s);       check(s, 8'h1C);
        set_cfg(8'h00);  check(translateEnable, 1'b0);
        $display("test config done");
    endtask
    task automatic t_kbd;
        set_cfg(8'h01);
        n = irq1Cnt;
        kbd_byte(8'h1C, 1'b1, 1'b0);
        status(s);       check(s, 8'h91);
        check(irq1Cnt - n, 1);
        read_data(r);    check(r, 8'h1C);
        status(s);       check(s[0], 1'b0);
        kbd_byte(8'h2A, 1'b0, 1'b1);
        status(s);       check(s, 8'h51);
        read_data(r);    check(r, 8'h2A);
        set_cfg(8'h00);
        n = irq1Cnt;
        kbd_byte(8'h33, 1'b0, 1'b0);
        read_data(r);    check(irq1Cnt - n, 0);
        $display("test keyboard done");
    endtask
    task automatic t_mouse;
        set_cfg(8'h02);
        n = irq12Cnt;
        mouse_byte(8'hAB);
        status(s);       check(s, 8'h31);
        check(irq12Cnt - n, 1);
        read_data(r);    check(r, 8'hAB);
        status(s);       check(s, 8'h10);
        set_cfg(8'h00);
        n = irq12Cnt;
        mouse_byte(8'h5A);
        read_data(r);    check(irq12Cnt - n, 0);
        $display("test mouse done");
    endtask
    task automatic t_lock;
        lockSwitchInput <= 1'b1;
        status(s);       check(s, 8'h00);
        kbd_byte(8'h1C, 1'b0, 1'b0);
        status(s);       check(s, 8'h00);
        set_cfg(8'h08);
        kbd_byte(8'h1C, 1'b0, 1'b0);
        status(s);       check(s, 8'h11);
        read_data(r);
        set_cfg(8'h00);
        lockSwitchInput <= 1'b0;
        $display("test lock done");
    endtask
    task automatic t_disable;
        cmd(`KMH_CMD_KBDIS);
        check({kbdClockLineOe, kbdClockLineOut}, 2'b10);
        kbd_byte(8'h1C, 1'b0, 1'b0);
        status(s);       check(s[0], 1'b0);
        cmd(`KMH_CMD_KBEN);
        check(kbdClockLineOe, 1'b0);
        cmd(`KMH_CMD_MSDIS);
        check(mouseEnable, 1'b0);
        cmd(`KMH_CMD_RDCFG);
        read_data(r);    check(r, 8'h20);
        cmd(`KMH_CMD_MSEN);
        check(mouseEnable, 1'b1);
        n = cmdCnt;
        cmd(8'hAA);      check(hostCmdByte, 8'hAA);
        check(cmdCnt - n, 1);
        $display("test disable done");
    endtask

    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        kbdValid = 1'b0;
        kbdCode = 8'h00;
        kbdParityErr = 1'b0;
        kbdTimeout = 1'b0;
        mouseValid = 1'b0;
        mouseCode = 8'h00;
        lockSwitchInput = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_config();
        t_kbd();
        t_mouse();
        t_lock();
        t_disable();
        print_verdict();
    end
endmodule
